// File: logic/wvrf_pkg.sv
// Constants shared by the wide vector register file and its helpers
package wvrf_pkg;
   // ----------------------------------------
   // Register geometry
   // ----------------------------------------
   localparam int VEC_W = 512;
   localparam int MID_W = 256;
   localparam int NAR_W = 128;
   localparam int NUM_REGS = 32;
   localparam int NUM_REGS32 = 8;
   localparam int IDX_W = 5;
   localparam int MASK_W = 64;
   localparam int NUM_MASKS = 8;
   localparam int KIDX_W = 3;
   localparam int ELEM32_W = 32;
   localparam int ELEM64_W = 64;
   // ----------------------------------------
   // Prefix field layout (payload bits)
   // ----------------------------------------
   localparam int PFX_W = 26;
   localparam int MM_LSB = 0;
   localparam int DST_LSB = 2;
   localparam int PP_LSB = 7;
   localparam int VSRC_LSB = 9;
   localparam int KSEL_LSB = 14;
   localparam int ZERO_BIT = 17;
   localparam int LL_LSB = 18;
   localparam int BCAST_BIT = 20;
   localparam int RSRC_LSB = 21;
   // ----------------------------------------
   // Field encodings
   // ----------------------------------------
   localparam logic [1:0] LL_128 = 2'h0;
   localparam logic [1:0] LL_256 = 2'h1;
   localparam logic [1:0] LL_512 = 2'h2;
   localparam logic [1:0] LL_BAD = 2'h3;
   localparam logic [1:0] ESC_NONE = 2'h0;
   localparam logic [1:0] ESC_0F = 2'h1;
   localparam logic [1:0] ESC_0F38 = 2'h2;
   localparam logic [1:0] ESC_0F3A = 2'h3;
   localparam logic [1:0] PP_NONE = 2'h0;
   localparam logic [1:0] PP_66 = 2'h1;
   localparam logic [1:0] PP_F3 = 2'h2;
   localparam logic [1:0] PP_F2 = 2'h3;
   localparam logic [KIDX_W-1:0] KSEL_NONE = 3'h0;
   localparam logic [IDX_W-1:0] IDX32_MASK = 5'h07;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [VEC_W-1:0] VEC_RST = '0;
   localparam logic [MASK_W-1:0] MASK_RST = 64'h0;
endpackage

// File: logic/wvrf_pfx_dec.sv
// Field decoder for the extended vector prefix payload
`timescale 1ns/1ps
module wvrf_pfx_dec (
   input wire logic [wvrf_pkg::PFX_W-1:0] pfx,
   input wire logic long_mode,
   input wire logic legacy,
   input wire logic mem,
   input wire logic fp_round,
   output logic [wvrf_pkg::IDX_W-1:0] dst,
   output logic [wvrf_pkg::IDX_W-1:0] vsrc,
   output logic [wvrf_pkg::IDX_W-1:0] rsrc,
   output logic [wvrf_pkg::KIDX_W-1:0] ksel,
   output logic zero,
   output logic [1:0] ll_eff,
   output logic bcast,
   output logic rnd_en,
   output logic [1:0] rnd_mode,
   output logic [1:0] simd_pfx,
   output logic [1:0] esc,
   output logic bad
);
   // Outside 64-bit mode only the low eight registers exist
   function automatic logic [wvrf_pkg::IDX_W-1:0] lim(input logic [wvrf_pkg::IDX_W-1:0] i, input logic lm);
      lim = lm ? i : (i & wvrf_pkg::IDX32_MASK);
   endfunction

   logic [1:0] ll;
   logic bbit;

   always_comb begin
      ll = pfx[wvrf_pkg::LL_LSB +: 2];
      bbit = pfx[wvrf_pkg::BCAST_BIT];
      dst = lim(pfx[wvrf_pkg::DST_LSB +: wvrf_pkg::IDX_W], long_mode);
      vsrc = lim(pfx[wvrf_pkg::VSRC_LSB +: wvrf_pkg::IDX_W], long_mode);
      rsrc = lim(pfx[wvrf_pkg::RSRC_LSB +: wvrf_pkg::IDX_W], long_mode);
      ksel = pfx[wvrf_pkg::KSEL_LSB +: wvrf_pkg::KIDX_W];
      zero = pfx[wvrf_pkg::ZERO_BIT];
      simd_pfx = pfx[wvrf_pkg::PP_LSB +: 2];
      esc = pfx[wvrf_pkg::MM_LSB +: 2];
      // The broadcast bit doubles as rounding enable on register-only math
      rnd_en = fp_round & ~mem & bbit;
      rnd_mode = rnd_en ? ll : 2'h0;
      ll_eff = rnd_en ? wvrf_pkg::LL_512 : ll;
      bcast = mem & bbit;
      bad = legacy | (esc == wvrf_pkg::ESC_NONE) | (~rnd_en & (ll == wvrf_pkg::LL_BAD));
   end
endmodule

// File: logic/wvrf_merge.sv
// Per-element merge or zero masking with upper-bit clearing
`timescale 1ns/1ps
module wvrf_merge #(
   parameter int VEC_W = wvrf_pkg::VEC_W
) (
   input wire logic [VEC_W-1:0] old_val,
   input wire logic [VEC_W-1:0] new_val,
   input wire logic [wvrf_pkg::MASK_W-1:0] kmask,
   input wire logic masked,
   input wire logic zero,
   input wire logic elem64,
   input wire logic [1:0] ll,
   output logic [VEC_W-1:0] res
);
   localparam int NCH = VEC_W / wvrf_pkg::ELEM32_W;
   int top;
   int e;

   always_comb begin
      res = '0;
      top = VEC_W;
      e = 0;
      if (ll == wvrf_pkg::LL_128) begin
         top = wvrf_pkg::NAR_W;
      end else if (ll == wvrf_pkg::LL_256) begin
         top = wvrf_pkg::MID_W;
      end
      for (int j = 0; j < NCH; j++) begin
         e = elem64 ? j / 2 : j;
         if ((j + 1) * wvrf_pkg::ELEM32_W > top) begin
            res[j*32 +: 32] = 32'h0;
         end else if (!masked || kmask[e]) begin
            res[j*32 +: 32] = new_val[j*32 +: 32];
         end else if (zero) begin
            res[j*32 +: 32] = 32'h0;
         end else begin
            res[j*32 +: 32] = old_val[j*32 +: 32];
         end
      end
   end
endmodule

// File: logic/wvrf_top.sv
// Wide vector register file with mask registers and masked writeback
//
// Notes on behaviour
// - Mid and narrow views are the low 256 and 128 bits of a wide register.
// - In 64-bit mode all 32 wide vector registers are addressable.
// - In 32-bit mode only the low 8 vector registers are addressable.
// - Eight mask registers, each 64 bits wide.
// - Only mask registers one to seven act as write predicates.
// - Mask select zero means unmasked: every element is written.
// - The zeroing select bit picks merging or zeroing masking.
// - Zeroing clears masked-off elements; merging is the default.
// - Results of 128 bits clear destination bits 511 down to 128.
// - Results of 256 bits clear destination bits 511 down to 256.
// - The prefix carries five register-select bits, reaching all 32 registers in 64-bit mode.
// - A second source register index is taken from the prefix.
// - The compacted prefix field yields the 66H, F2H or F3H opcode extension.
// - The compacted escape field yields 0FH, 0F38H or 0F3AH.
// - Memory-source broadcast replicates element zero across all lanes.
// - Register-only FP rounding takes its mode from prefix bits at 512 bits.
// - The prefix is refused for legacy integer or float stack operations.
`timescale 1ns/1ps
module wvrf_top (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic long_mode,
   input wire logic op_valid,
   input wire logic [wvrf_pkg::PFX_W-1:0] op_pfx,
   input wire logic op_legacy,
   input wire logic op_mem,
   input wire logic op_fp_round,
   input wire logic op_elem64,
   input wire logic [wvrf_pkg::VEC_W-1:0] op_data,
   input wire logic rd_en,
   input wire logic [wvrf_pkg::IDX_W-1:0] rd_idx,
   input wire logic [1:0] rd_width,
   input wire logic km_wr_en,
   input wire logic [wvrf_pkg::KIDX_W-1:0] km_idx,
   input wire logic [wvrf_pkg::MASK_W-1:0] km_data,
   input wire logic [wvrf_pkg::KIDX_W-1:0] km_rd_idx,
   output logic wb_valid_q,
   output logic [wvrf_pkg::IDX_W-1:0] wb_idx_q,
   output logic [wvrf_pkg::VEC_W-1:0] wb_data_q,
   output logic op_err_q,
   output logic [wvrf_pkg::IDX_W-1:0] dec_vsrc_q,
   output logic [wvrf_pkg::IDX_W-1:0] dec_rsrc_q,
   output logic [1:0] dec_simd_pfx_q,
   output logic [1:0] dec_esc_q,
   output logic rnd_en_q,
   output logic [1:0] rnd_mode_q,
   output logic [wvrf_pkg::VEC_W-1:0] rd_data_q,
   output logic [wvrf_pkg::MASK_W-1:0] km_rd_data_q
);
   // ----------------------------------------
   // Storage
   // ----------------------------------------
   logic [wvrf_pkg::VEC_W-1:0] vregs_q [wvrf_pkg::NUM_REGS];
   logic [wvrf_pkg::MASK_W-1:0] kregs_q [wvrf_pkg::NUM_MASKS];

   // ----------------------------------------
   // Prefix decode
   // ----------------------------------------
   logic [wvrf_pkg::IDX_W-1:0] dst;
   logic [wvrf_pkg::IDX_W-1:0] vsrc;
   logic [wvrf_pkg::IDX_W-1:0] rsrc;
   logic [wvrf_pkg::KIDX_W-1:0] ksel;
   logic zero;
   logic [1:0] ll_eff;
   logic bcast;
   logic rnd_en;
   logic [1:0] rnd_mode;
   logic [1:0] simd_pfx;
   logic [1:0] esc;
   logic bad;
   logic accept;

   wvrf_pfx_dec u_dec (
      .pfx(op_pfx),
      .long_mode(long_mode),
      .legacy(op_legacy),
      .mem(op_mem),
      .fp_round(op_fp_round),
      .dst(dst),
      .vsrc(vsrc),
      .rsrc(rsrc),
      .ksel(ksel),
      .zero(zero),
      .ll_eff(ll_eff),
      .bcast(bcast),
      .rnd_en(rnd_en),
      .rnd_mode(rnd_mode),
      .simd_pfx(simd_pfx),
      .esc(esc),
      .bad(bad)
   );

   assign accept = op_valid & ~bad;

   // ----------------------------------------
   // Source shaping and masking
   // ----------------------------------------
   logic [wvrf_pkg::VEC_W-1:0] src_val;
   logic [wvrf_pkg::VEC_W-1:0] old_val;
   logic [wvrf_pkg::VEC_W-1:0] wb_d;
   logic masked;

   always_comb begin
      src_val = op_data;
      if (bcast) begin
         for (int j = 0; j < wvrf_pkg::VEC_W / wvrf_pkg::ELEM64_W; j++) begin
            if (op_elem64) begin
               src_val[j*64 +: 64] = op_data[63:0];
            end else begin
               src_val[j*64 +: 64] = {op_data[31:0], op_data[31:0]};
            end
         end
      end
   end

   // Mask zero is never a predicate, so it cannot hide elements
   assign masked = (ksel != wvrf_pkg::KSEL_NONE);
   assign old_val = vregs_q[dst];

   wvrf_merge #(
      .VEC_W(wvrf_pkg::VEC_W)
   ) u_merge (
      .old_val(old_val),
      .new_val(src_val),
      .kmask(kregs_q[ksel]),
      .masked(masked),
      .zero(zero),
      .elem64(op_elem64),
      .ll(ll_eff),
      .res(wb_d)
   );

   // ----------------------------------------
   // Vector register writeback
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < wvrf_pkg::NUM_REGS; i++) begin
            vregs_q[i] <= wvrf_pkg::VEC_RST;
         end
      end else if (accept) begin
         vregs_q[dst] <= wb_d;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wb_valid_q <= 1'b0;
         wb_idx_q <= '0;
         wb_data_q <= wvrf_pkg::VEC_RST;
         op_err_q <= 1'b0;
      end else begin
         wb_valid_q <= accept;
         op_err_q <= op_valid & bad;
         if (accept) begin
            wb_idx_q <= dst;
            wb_data_q <= wb_d;
         end
      end
   end

   // ----------------------------------------
   // Decode results toward the execution units
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         dec_vsrc_q <= '0;
         dec_rsrc_q <= '0;
         dec_simd_pfx_q <= wvrf_pkg::PP_NONE;
         dec_esc_q <= wvrf_pkg::ESC_NONE;
         rnd_en_q <= 1'b0;
         rnd_mode_q <= 2'h0;
      end else if (accept) begin
         dec_vsrc_q <= vsrc;
         dec_rsrc_q <= rsrc;
         dec_simd_pfx_q <= simd_pfx;
         dec_esc_q <= esc;
         rnd_en_q <= rnd_en;
         rnd_mode_q <= rnd_mode;
      end else begin
         rnd_en_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // Mask registers
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < wvrf_pkg::NUM_MASKS; i++) begin
            kregs_q[i] <= wvrf_pkg::MASK_RST;
         end
      end else if (km_wr_en) begin
         kregs_q[km_idx] <= km_data;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         km_rd_data_q <= wvrf_pkg::MASK_RST;
      end else begin
         km_rd_data_q <= kregs_q[km_rd_idx];
      end
   end

   // ----------------------------------------
   // Read port with narrow and mid views
   // ----------------------------------------
   logic [wvrf_pkg::IDX_W-1:0] rd_sel;
   logic [wvrf_pkg::VEC_W-1:0] rd_view;

   always_comb begin
      rd_sel = long_mode ? rd_idx : (rd_idx & wvrf_pkg::IDX32_MASK);
      rd_view = vregs_q[rd_sel];
      if (rd_width == wvrf_pkg::LL_128) begin
         rd_view[wvrf_pkg::VEC_W-1:wvrf_pkg::NAR_W] = '0;
      end else if (rd_width == wvrf_pkg::LL_256) begin
         rd_view[wvrf_pkg::VEC_W-1:wvrf_pkg::MID_W] = '0;
      end
   end

   // Reads return the value before a same-cycle write
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rd_data_q <= wvrf_pkg::VEC_RST;
      end else if (rd_en) begin
         rd_data_q <= rd_view;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   logic plain_wr;
   assign plain_wr = accept & ~bcast & ~masked & (ll_eff == wvrf_pkg::LL_512);

   property p_legacy_refused;
      @(posedge core_clk) disable iff (sys_rst)
      op_valid && op_legacy |=> op_err_q && !wb_valid_q;
   endproperty
   a_legacy_refused: assert property (p_legacy_refused) else $error("legacy op was written");

   property p_mode32_dst;
      @(posedge core_clk) disable iff (sys_rst)
      accept && !long_mode |=> wb_idx_q < 5'(wvrf_pkg::NUM_REGS32);
   endproperty
   a_mode32_dst: assert property (p_mode32_dst) else $error("32-bit mode reached high register");

   property p_full_idx;
      @(posedge core_clk) disable iff (sys_rst)
      accept && long_mode |=> wb_idx_q == $past(op_pfx[wvrf_pkg::DST_LSB +: wvrf_pkg::IDX_W]);
   endproperty
   a_full_idx: assert property (p_full_idx) else $error("64-bit mode index altered");

   property p_clear128;
      @(posedge core_clk) disable iff (sys_rst)
      accept && ll_eff == wvrf_pkg::LL_128 |=> wb_data_q[511:128] == '0;
   endproperty
   a_clear128: assert property (p_clear128) else $error("bits above 128 not cleared");

   property p_clear256;
      @(posedge core_clk) disable iff (sys_rst)
      accept && ll_eff == wvrf_pkg::LL_256 |=> wb_data_q[511:256] == '0 && wb_valid_q;
   endproperty
   a_clear256: assert property (p_clear256) else $error("bits above 256 not cleared");

   property p_unmasked;
      @(posedge core_clk) disable iff (sys_rst)
      plain_wr |=> wb_data_q == $past(op_data);
   endproperty
   a_unmasked: assert property (p_unmasked) else $error("unmasked write altered data");

   property p_zeroing;
      @(posedge core_clk) disable iff (sys_rst)
      accept && masked && zero && !kregs_q[ksel][0] |=> wb_data_q[31:0] == 32'h0;
   endproperty
   a_zeroing: assert property (p_zeroing) else $error("masked-off element not zeroed");

   property p_merging;
      @(posedge core_clk) disable iff (sys_rst)
      accept && masked && !zero && !kregs_q[ksel][0] |=> wb_data_q[31:0] == $past(old_val[31:0]);
   endproperty
   a_merging: assert property (p_merging) else $error("masked-off element not kept");

   property p_bcast;
      @(posedge core_clk) disable iff (sys_rst)
      accept && bcast && !masked && op_elem64 && ll_eff == wvrf_pkg::LL_512
      |=> wb_data_q[511:448] == $past(op_data[63:0]);
   endproperty
   a_bcast: assert property (p_bcast) else $error("broadcast lane mismatch");

   property p_round;
      @(posedge core_clk) disable iff (sys_rst)
      accept && rnd_en |=> rnd_en_q && rnd_mode_q == $past(op_pfx[wvrf_pkg::LL_LSB +: 2]);
   endproperty
   a_round: assert property (p_round) else $error("rounding mode not taken");

   property p_escape;
      @(posedge core_clk) disable iff (sys_rst)
      accept |=> dec_esc_q == $past(op_pfx[wvrf_pkg::MM_LSB +: 2])
      && dec_simd_pfx_q == $past(op_pfx[wvrf_pkg::PP_LSB +: 2]);
   endproperty
   a_escape: assert property (p_escape) else $error("escape field lost");

   property p_view128;
      @(posedge core_clk) disable iff (sys_rst)
      rd_en && rd_width == wvrf_pkg::LL_128 |=> rd_data_q[511:128] == '0;
   endproperty
   a_view128: assert property (p_view128) else $error("narrow view leaked upper bits");

   c_zeroing: cover property (@(posedge core_clk) disable iff (sys_rst) accept && masked && zero);
   c_merging: cover property (@(posedge core_clk) disable iff (sys_rst) accept && masked && !zero);
   c_round: cover property (@(posedge core_clk) disable iff (sys_rst) accept && rnd_en);
   c_refused: cover property (@(posedge core_clk) disable iff (sys_rst) op_valid && bad);
endmodule

// File: sim/wvrf_dec_model.sv
// Decoder-side model that issues one operation at a time
`timescale 1ns/1ps
module wvrf_dec_model (
   input wire logic core_clk,
   output logic op_valid,
   output logic [wvrf_pkg::PFX_W-1:0] op_pfx,
   output logic op_legacy,
   output logic op_mem,
   output logic op_fp_round,
   output logic op_elem64,
   output logic [wvrf_pkg::VEC_W-1:0] op_data
);
   initial begin
      op_valid = 1'h0;
      op_pfx = '0;
      {op_legacy, op_mem, op_fp_round, op_elem64} = 4'h0;
      op_data = '0;
   end
   // ----------------------------------------
   // One-cycle request, flags given as {elem64, fp_round, mem, legacy}
   // ----------------------------------------
   task automatic issue(input logic [25:0] p, input logic [511:0] d, input logic [3:0] f);
      @(posedge core_clk);
      op_valid <= 1'h1;
      op_pfx <= p;
      op_data <= d;
      {op_elem64, op_fp_round, op_mem, op_legacy} <= f;
      @(posedge core_clk);
      op_valid <= 1'h0;
      // Released payload must not keep looking valid
      op_pfx <= ~p;
      op_data <= ~d;
   endtask
endmodule

// File: sim/wvrf_top_tb.sv
// Self-checking bench for the wide vector register file
`timescale 1ns/1ps
module wvrf_top_tb;
   logic core_clk, sys_rst, long_mode, rd_en, km_wr_en, op_valid, op_legacy, op_mem, op_fp_round, op_elem64;
   logic [25:0] op_pfx;
   logic [511:0] op_data, wb_data_q, rd_data_q;
   logic [4:0] rd_idx, wb_idx_q, dec_vsrc_q, dec_rsrc_q;
   logic [2:0] km_idx, km_rd_idx;
   logic [1:0] rd_width, dec_simd_pfx_q, dec_esc_q, rnd_mode_q;
   logic [63:0] km_data, km_rd_data_q;
   logic wb_valid_q, op_err_q, rnd_en_q;
   logic [511:0] rf [32];
   logic [63:0] km [8];
   int error_cnt, comparisons;

   wvrf_dec_model model (.core_clk(core_clk), .op_valid(op_valid), .op_pfx(op_pfx), .op_legacy(op_legacy),
      .op_mem(op_mem), .op_fp_round(op_fp_round), .op_elem64(op_elem64), .op_data(op_data));
   wvrf_top uut (.core_clk(core_clk), .sys_rst(sys_rst), .long_mode(long_mode), .op_valid(op_valid),
      .op_pfx(op_pfx), .op_legacy(op_legacy), .op_mem(op_mem), .op_fp_round(op_fp_round),
      .op_elem64(op_elem64), .op_data(op_data), .rd_en(rd_en), .rd_idx(rd_idx), .rd_width(rd_width),
      .km_wr_en(km_wr_en), .km_idx(km_idx), .km_data(km_data), .km_rd_idx(km_rd_idx),
      .wb_valid_q(wb_valid_q), .wb_idx_q(wb_idx_q), .wb_data_q(wb_data_q), .op_err_q(op_err_q),
      .dec_vsrc_q(dec_vsrc_q), .dec_rsrc_q(dec_rsrc_q), .dec_simd_pfx_q(dec_simd_pfx_q),
      .dec_esc_q(dec_esc_q), .rnd_en_q(rnd_en_q), .rnd_mode_q(rnd_mode_q), .rd_data_q(rd_data_q),
      .km_rd_data_q(km_rd_data_q));

   initial begin
      core_clk = 1'h0;
      forever #25 core_clk = ~core_clk;
   end
   // ----------------------------------------
   // Compare, golden model and port tasks
   // ----------------------------------------
   task automatic chk512(input logic [511:0] e, input logic [511:0] a);
      comparisons++;
      if (a !== e) begin
         error_cnt++;
         $display("Error t=%0t exp=%h act=%h", $time, e, a);
      end
   endtask
   task automatic chk64(input logic [63:0] e, input logic [63:0] a);
      comparisons++;
      if (a !== e) begin
         error_cnt++;
         $display("Error t=%0t exp=%h act=%h", $time, e, a);
      end
   endtask
   task automatic summarize();
      $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   function automatic logic [25:0] pf(input logic [1:0] es, input logic [4:0] ds, input logic [1:0] pp,
      input logic [4:0] vs, input logic [2:0] ks, input logic z, input logic [1:0] ll, input logic b,
      input logic [4:0] rs);
      return {rs, b, ll, z, ks, vs, pp, ds, es};
   endfunction
   function automatic logic [511:0] pat(input logic [7:0] s);
      logic [511:0] r;
      for (int c = 0; c < 16; c++) r[c*32+:32] = {s, 8'h5a, 8'(c), ~s};
      return r;
   endfunction
   // Element e covers one 32-bit chunk, or two when elements are 64 bits
   function automatic logic [511:0] mrg(input logic [511:0] o, input logic [511:0] n, input logic [63:0] k,
      input logic m, input logic z, input logic e, input logic [1:0] l);
      logic [511:0] r;
      int lim;
      lim = (l == 2'h0) ? 4 : ((l == 2'h1) ? 8 : 16);
      for (int c = 0; c < 16; c++) begin
         if (c >= lim) r[c*32+:32] = 32'h0;
         else if (!m || k[e ? c / 2 : c]) r[c*32+:32] = n[c*32+:32];
         else r[c*32+:32] = z ? 32'h0 : o[c*32+:32];
      end
      return r;
   endfunction
   task automatic op(input logic [25:0] p, input logic [511:0] d, input logic [3:0] f);
      logic [4:0] ds;
      logic [1:0] ll;
      logic rnd, bad;
      logic [511:0] nd, e;
      model.issue(p, d, f);
      #1;
      // Work out the expectation with the mode in force when the op was taken
      ds = long_mode ? p[6:2] : {2'h0, p[4:2]};
      rnd = f[2] & ~f[1] & p[20];
      ll = rnd ? 2'h2 : p[19:18];
      bad = f[0] | (p[1:0] == 2'h0) | (p[19:18] == 2'h3 & !rnd);
      nd = (f[1] & p[20]) ? (f[3] ? {8{d[63:0]}} : {16{d[31:0]}}) : d;
      e = mrg(rf[ds], nd, km[p[16:14]], p[16:14] != 3'h0, p[17], f[3], ll);
      chk64(64'(bad), 64'(op_err_q));
      chk64(64'(!bad), 64'(wb_valid_q));
      chk64(64'(rnd & !bad), 64'(rnd_en_q));
      if (!bad) begin
         chk64(64'(ds), 64'(wb_idx_q));
         chk512(e, wb_data_q);
         rf[ds] = e;
      end
   endtask
   task automatic kw(input logic [2:0] i, input logic [63:0] d);
      @(posedge core_clk);
      km_wr_en <= 1'h1;
      km_idx <= i;
      km_data <= d;
      @(posedge core_clk);
      km_wr_en <= 1'h0;
      km_data <= ~d;
      km[i] = d;
   endtask
   task automatic rk(input logic [2:0] i);
      @(posedge core_clk);
      km_rd_idx <= i;
      @(posedge core_clk);
      #1 chk64(km[i], km_rd_data_q);
   endtask
   task automatic rd(input logic [4:0] i, input logic [1:0] w);
      logic [511:0] e;
      @(posedge core_clk);
      rd_en <= 1'h1;
      rd_idx <= i;
      rd_width <= w;
      @(posedge core_clk);
      rd_en <= 1'h0;
      #1;
      e = rf[long_mode ? i : i & 5'h07];
      if (w == 2'h0) e[511:128] = '0;
      if (w == 2'h1) e[511:256] = '0;
      chk512(e, rd_data_q);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_dec();
      op(pf(2'h1, 5'h1f, 2'h1, 5'h15, 3'h0, 1'h0, 2'h2, 1'h0, 5'h0e), pat(8'h10), 4'h0);
      chk64(64'h15, 64'(dec_vsrc_q));
      chk64(64'h0e, 64'(dec_rsrc_q));
      for (int i = 0; i < 4; i++) begin
         op(pf(i == 0 ? 2'h1 : 2'(i), 5'(20 + i), 2'(i), 5'h0, 3'h0, 1'h0, 2'h2, 1'h0, 5'h0), pat(8'(i)), 4'h0);
         chk64(64'(i == 0 ? 1 : i), 64'(dec_esc_q));
         chk64(64'(i), 64'(dec_simd_pfx_q));
      end
      for (int w = 0; w < 3; w++) rd(5'h1f, 2'(w));
   endtask
   task automatic t_mask();
      kw(3'h0, 64'h5);
      // Element zero is masked off in both predicates so the merge and zero paths act on it
      kw(3'h1, 64'ha5c2);
      kw(3'h7, 64'hffff_0000_0000_0002);
      rk(3'h1);
      rk(3'h7);
      op(pf(2'h1, 5'h1f, 2'h0, 5'h0, 3'h0, 1'h0, 2'h2, 1'h0, 5'h0), pat(8'h20), 4'h0);
      op(pf(2'h1, 5'h1f, 2'h0, 5'h0, 3'h1, 1'h0, 2'h2, 1'h0, 5'h0), pat(8'h30), 4'h0);
      op(pf(2'h1, 5'h1f, 2'h0, 5'h0, 3'h7, 1'h1, 2'h2, 1'h0, 5'h0), pat(8'h40), 4'h8);
      op(pf(2'h1, 5'h1f, 2'h0, 5'h0, 3'h0, 1'h0, 2'h0, 1'h0, 5'h0), pat(8'h41), 4'h0);
      op(pf(2'h1, 5'h1f, 2'h0, 5'h0, 3'h1, 1'h0, 2'h1, 1'h0, 5'h0), pat(8'h42), 4'h0);
   endtask
   task automatic t_misc();
      op(pf(2'h2, 5'h04, 2'h0, 5'h0, 3'h0, 1'h0, 2'h2, 1'h1, 5'h0), pat(8'h50), 4'h2);
      op(pf(2'h2, 5'h04, 2'h0, 5'h0, 3'h0, 1'h0, 2'h2, 1'h1, 5'h0), pat(8'h51), 4'ha);
      for (int m = 0; m < 4; m++) begin
         op(pf(2'h3, 5'h05, 2'h0, 5'h0, 3'h0, 1'h0, 2'(m), 1'h1, 5'h0), pat(8'(m + 8'h60)), 4'h4);
         chk64(64'(m), 64'(rnd_mode_q));
      end
      op(pf(2'h1, 5'h06, 2'h1, 5'h0, 3'h0, 1'h0, 2'h2, 1'h0, 5'h0), pat(8'h70), 4'h1);
      op(pf(2'h0, 5'h06, 2'h1, 5'h0, 3'h0, 1'h0, 2'h2, 1'h0, 5'h0), pat(8'h71), 4'h0);
      op(pf(2'h1, 5'h06, 2'h1, 5'h0, 3'h0, 1'h0, 2'h3, 1'h0, 5'h0), pat(8'h72), 4'h0);
      chk64(64'h3, 64'(dec_esc_q));
      rd(5'h06, 2'h2);
      @(posedge core_clk) long_mode <= 1'h0;
      op(pf(2'h1, 5'h1b, 2'h0, 5'h0, 3'h0, 1'h0, 2'h2, 1'h0, 5'h0), pat(8'h80), 4'h0);
      rd(5'h1b, 2'h2);
      @(posedge core_clk) long_mode <= 1'h1;
      rd(5'h1b, 2'h2);
   endtask

   initial begin
      repeat (20000) @(posedge core_clk);
      error_cnt++;
      summarize();
   end
   initial begin
      sys_rst = 1'h1;
      long_mode = 1'h1;
      {rd_en, km_wr_en, rd_idx, rd_width, km_idx, km_rd_idx, km_data} = '0;
      foreach (rf[i]) rf[i] = '0;
      foreach (km[i]) km[i] = '0;
      repeat (4) @(posedge core_clk);
      sys_rst <= 1'h0;
      rd(5'h00, 2'h2);
      rk(3'h3);
      t_dec();
      t_mask();
      t_misc();
      summarize();
   end
endmodule
